// [test/sfi_ctrl_model.sv]
// Purpose: Two-wire bus controller model facing the serial memory target
// Assumes: Half period of the serial clock given in mclk cycles
// Notes:   A released data line reads high through the pull-up
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module sfi_ctrl_model #(
  parameter int unsigned H = 100
) (
  input  wire logic mclk_i,
  input  wire logic sda_i,
  output var logic  scl_o,
  output var logic  sda_o
);
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  task automatic wt(input int unsigned n);
    repeat (n) @(negedge mclk_i);
  endtask

  // Start from idle or, as a repeated start, from a low clock
  task automatic start();
    sda_o = 1'b1;
    wt(H);
    scl_o = 1'b1;
    wt(H);
    sda_o = 1'b0;
    wt(H);
    scl_o = 1'b0;
  endtask

  task automatic stop();
    wt(H / 4);
    sda_o = 1'b0;
    wt(H);
    scl_o = 1'b1;
    wt(H);
    sda_o = 1'b1;
    wt(H);
  endtask

  // Data changes while the clock is low, sampled in mid-high
  task automatic clk_bit(input logic b, output logic r);
    wt(H / 4);
    sda_o = b;
    wt(H - H / 4);
    scl_o = 1'b1;
    wt(H / 2);
    r = sda_i;
    wt(H - H / 2);
    scl_o = 1'b0;
  endtask

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      clk_bit(d[i], r);
    clk_bit(1'b1, r);
    ack = ~r;
  endtask

  task automatic rbyte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      clk_bit(1'b1, d[i]);
    clk_bit(~more, r); // Withheld ack after the last byte
  endtask
endmodule // sfi_ctrl_model
`default_nettype wire

// [test/sfi_target_tb.sv]
// Purpose: Self-checking bench of the serial memory target
// Assumes: 200 MHz mclk, serial clock at 1 MHz from the controller model
// Notes:   Only bytes written by the bench are compared on read
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module sfi_target_tb import sfi_pkg::*; ();
  localparam logic [3:0]  DEV  = 4'h5; // Device type, value is arbitrary
  localparam int unsigned HALF = 100; // 1 MHz serial clock
  logic       mclk;
  logic       resetn;
  logic       wp;
  logic       scl;
  logic       m_sda;
  logic       dev_sda;
  logic       oe_n;
  logic       sda;
  logic [2:0] s;
  logic [7:0] r;
  logic       k;
  int         error_cnt;
  int         compares;
  logic [7:0] exp_mem [SFI_BYTES];

  assign sda = m_sda & (oe_n | dev_sda); // Wired-AND with pull-up

  sfi_target #(.DEV_TYPE(DEV)) uut (.mclk_i(mclk), .resetn_i(resetn), .scl_i(scl), .sda_i(sda),
    .sda_o(dev_sda), .sda_oe_n_o(oe_n), .wp_i(wp));
  sfi_ctrl_model #(.H(HALF)) m (.mclk_i(mclk), .sda_i(sda), .scl_o(scl), .sda_o(m_sda));

  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [10:0] seen, input logic [10:0] want);
    compares++;
    if (seen !== want)
    begin
      $display("[FAIL] %s expected %h seen %h", what, want, seen);
      error_cnt++;
    end
  endtask

  function automatic logic [7:0] devb(input logic [2:0] sg, input logic rw);
    return {DEV, sg, rw};
  endfunction

  task automatic wr_at(input logic [2:0] sg, input logic [7:0] rw, input int n);
    logic [10:0] a;
    logic [7:0]  d;
    logic        ak;
    a = {sg, rw}; // Segment over row
    m.start();
    m.wbyte(devb(sg, 1'b0), ak);
    chk("addr byte ack", ak, 1'b1);
    m.wbyte(rw, ak);
    chk("row ack", ak, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      d = 8'($urandom);
      m.wbyte(d, ak);
      chk("data ack", ak, 1'b1);
      if (wp === 1'b0)
        exp_mem[a] = d; // Protected bytes leave the array alone
      a = a + 11'h001; // Wraps from top to zero
    end
    m.stop();
  endtask

  // Latch a row through segment sg, then read n bytes through segment rs
  task automatic rd_at(input logic [2:0] sg, input logic [7:0] rw, input logic [2:0] rs, input int n);
    logic [10:0] a;
    logic [7:0]  d;
    logic        ak;
    wr_at(sg, rw, 0);
    a = {rs, rw};
    m.start();
    m.wbyte(devb(rs, 1'b1), ak);
    chk("read addr ack", ak, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      m.rbyte(i != n - 1, d);
      chk("read data", d, exp_mem[a]);
      a = a + 11'h001;
    end
    m.wt(HALF / 2);
    chk("released after nack", oe_n, 1'b1);
    m.stop();
  endtask

  task automatic complete_run();
    $display("Comparisons %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    // The tests need about 84000 cycles; the limit stays under 100000
    repeat (95000) @(posedge mclk);
    error_cnt++;
    $display("[FAIL] watchdog expected end seen hang");
    complete_run();
  end

  initial
  begin
    resetn = 1'b0;
    wp = 1'b0; // Unconnected protect pin reads low
    error_cnt = 0;
    compares = 0;
    void'($urandom(32'h455ECE2B));
    repeat (4) @(negedge mclk);
    chk("released in reset", oe_n, 1'b1);
    chk("drive level", dev_sda, 1'b0);
    resetn = 1'b1;
    repeat (4) @(negedge mclk);
    $display("test reset done");
    wr_at(3'h7, 8'hFF, 3);
    rd_at(3'h3, 8'hFF, 3'h7, 3);
    $display("test wrap done");
    repeat (2)
    begin
      s = 3'($urandom);
      r = 8'($urandom);
      wr_at(s, r, 1);
      rd_at(s + 3'h1, r, s, 1);
    end
    $display("test random done");
    wp = 1'b1;
    wr_at(3'h0, 8'h00, 1);
    wp = 1'b0;
    rd_at(3'h0, 8'h00, 3'h0, 1);
    $display("test protect done");
    m.start();
    m.wbyte(devb(3'h0, 1'b0), k);
    m.wbyte(8'h00, k);
    for (int i = 0; i < 5; i++)
      m.clk_bit(~exp_mem[11'h000][7 - i], k);
    m.start();
    m.wbyte(devb(3'h0, 1'b0), k);
    chk("ack after abort", k, 1'b1);
    m.stop();
    rd_at(3'h0, 8'h00, 3'h0, 1);
    $display("test abort done");
    m.start();
    m.wbyte({~DEV, 3'h0, 1'b1}, k);
    chk("foreign type nack", k, 1'b0);
    m.stop();
    $display("test foreign done");
    complete_run();
  end
endmodule // sfi_target_tb
`default_nettype wire

// [verilog/sfi_pkg.sv]
// Purpose: Shared constants and types of the serial memory target
// Assumes: mclk_i at 200 MHz, serial clock up to 1 MHz
// Notes:   Byte address is segment (3 bits) over row (8 bits)
`default_nettype none
package sfi_pkg;

  localparam int unsigned SFI_ADDR_W     = 11;
  localparam int unsigned SFI_BYTES      = 2048;
  localparam int unsigned SFI_FIFO_DEPTH = 16;
  localparam int unsigned SFI_MCLK_KHZ   = 200000;
  localparam int unsigned SFI_SCL_MAX_KHZ = 1000;
  // Shortest serial clock period in mclk cycles (1 MHz top rate)
  localparam int unsigned SFI_SCL_MIN_CYC = SFI_MCLK_KHZ / SFI_SCL_MAX_KHZ;

  localparam logic [3:0]  SFI_LAST_BIT = 4'h7;
  localparam logic [3:0]  SFI_ACK_BIT  = 4'h8;
  localparam logic [3:0]  SFI_CNT_RST  = 4'h0;
  localparam logic [10:0] SFI_ADDR_RST = 11'h000;
  localparam logic [10:0] SFI_ADDR_ONE = 11'h001;

  typedef enum logic [4:0]
  {
    S_IDLE  = 5'b00001,
    S_DEV   = 5'b00010,
    S_WADDR = 5'b00100,
    S_WDATA = 5'b01000,
    S_RDATA = 5'b10000
  } sfi_state_t;

  typedef struct packed
  {
    logic [10:0] addr;
    logic [7:0]  data;
  } sfi_wr_t;

  typedef struct packed
  {
    logic [1:0]  scl_sy;
    logic [1:0]  sda_sy;
    logic        sda_d;
    logic [1:0]  wp_sy;
    logic [3:0]  tog_sy;
    logic [1:0]  bit_sy;
    sfi_state_t  state;
    logic [3:0]  cnt;
    logic [7:0]  shreg;
    logic [10:0] addr;
    logic        rw;
    logic        ack_ok;
    logic        plan;
    logic        live;
    logic [7:0]  txd;
    logic        push;
    sfi_wr_t     wr;
  } sfi_core_t;

  localparam sfi_core_t SFI_CORE_RST = '{
    scl_sy: 2'h3, sda_sy: 2'h3, sda_d: 1'b1, wp_sy: 2'h0, tog_sy: 4'h0,
    bit_sy: 2'h3, state: S_IDLE, cnt: 4'h0, shreg: 8'h00, addr: 11'h000,
    rw: 1'b0, ack_ok: 1'b0, plan: 1'b0, live: 1'b0, txd: 8'hFF,
    push: 1'b0, wr: 19'h00000};

endpackage
`default_nettype wire

// [verilog/sfi_target.sv]
// Purpose: Target logic of a 2048-byte serial memory on a two-wire bus
// Assumes: scl_i clocks the link flops; protocol runs on mclk_i
// Notes:   Write bytes pass a small FIFO on their way to the array
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module sfi_fifo #(
  parameter int unsigned W = 19,
  parameter int unsigned D = 16
) (
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int unsigned AW = $clog2(D);

  typedef struct packed
  {
    logic [AW:0] wptr;
    logic [AW:0] rptr;
  } sfi_fptr_t;

  sfi_fptr_t   ptr_reg;
  sfi_fptr_t   ptr_next;
  logic [W-1:0] store [D];

  assign out_valid_o = ptr_reg.wptr != ptr_reg.rptr;
  assign in_ready_o  = (ptr_reg.wptr[AW-1:0] != ptr_reg.rptr[AW-1:0]) ||
                       (ptr_reg.wptr[AW] == ptr_reg.rptr[AW]);
  assign out_data_o  = store[ptr_reg.rptr[AW-1:0]];

  always_comb
  begin
    ptr_next = ptr_reg;
    if (in_valid_i && in_ready_o)
    begin
      ptr_next.wptr = ptr_reg.wptr + 1'b1;
    end
    if (out_valid_o && out_ready_i)
    begin
      ptr_next.rptr = ptr_reg.rptr + 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ptr_reg <= '0;
    end
    else
    begin
      ptr_reg <= ptr_next;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (in_valid_i && in_ready_o)
    begin
      store[ptr_reg.wptr[AW-1:0]] <= in_data_i;
    end
  end
endmodule // sfi_fifo

////////////////////////////////////////////////////////////////////////////////
module sfi_target import sfi_pkg::*; #(
  // Device type code; value is arbitrary
  parameter logic [3:0] DEV_TYPE = 4'h5
) (
  input  wire logic mclk_i,
  input  wire logic resetn_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe_n_o,
  input  wire logic wp_i
);

  function automatic logic is_rx(input sfi_state_t s);
    is_rx = (s == S_DEV) || (s == S_WADDR) || (s == S_WDATA);
  endfunction

  function automatic logic is_busy(input sfi_state_t s);
    is_busy = (s != S_IDLE);
  endfunction

  sfi_core_t   core_reg;
  sfi_core_t   core_next;
  logic        link_bit_reg;
  logic        link_tog_reg;
  logic        link_low_reg;
  logic [7:0]  rd_q;
  logic [7:0]  mem [SFI_BYTES];
  logic        start_ev;
  logic        stop_ev;
  logic        rise_ev;
  logic        bit_v;
  logic        byte_done;
  logic        ack_slot;
  logic        wp_on;
  logic [7:0]  byte_in;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic        drain_ready;
  logic        mem_we;
  sfi_wr_t     fifo_out;

  //////////////////////////////////////////////////////////////////////////////
  // Link domain: capture on rise, drive on fall
  always_ff @(posedge scl_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      link_bit_reg <= 1'b1;
      link_tog_reg <= 1'b0;
    end
    else
    begin
      link_bit_reg <= sda_i;
      link_tog_reg <= ~link_tog_reg;
    end
  end

  // Plan is settled a few mclk cycles after the rise and held until the fall
  always_ff @(negedge scl_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      link_low_reg <= 1'b0;
    end
    else
    begin
      link_low_reg <= core_reg.plan;
    end
  end

  assign sda_o      = 1'b0;
  assign sda_oe_n_o = ~(link_low_reg & core_reg.live);

  //////////////////////////////////////////////////////////////////////////////
  // Bus conditions and bit events in the mclk domain
  assign start_ev  = core_reg.scl_sy[1] & core_reg.sda_d & ~core_reg.sda_sy[1];
  assign stop_ev   = core_reg.scl_sy[1] & ~core_reg.sda_d & core_reg.sda_sy[1];
  assign rise_ev   = core_reg.tog_sy[2] ^ core_reg.tog_sy[3];
  assign bit_v     = core_reg.bit_sy[1];
  assign byte_in   = {core_reg.shreg[6:0], bit_v};
  assign byte_done = rise_ev && (core_reg.cnt == SFI_LAST_BIT) && is_busy(core_reg.state);
  assign ack_slot  = rise_ev && (core_reg.cnt == SFI_ACK_BIT) && is_busy(core_reg.state);
  // A floating pin is pulled down at the pad, so only a solid high protects
  assign wp_on     = core_reg.wp_sy[1];

  always_comb
  begin
    core_next        = core_reg;
    core_next.scl_sy = {core_reg.scl_sy[0], scl_i};
    core_next.sda_sy = {core_reg.sda_sy[0], sda_i};
    core_next.sda_d  = core_reg.sda_sy[1];
    core_next.wp_sy  = {core_reg.wp_sy[0], wp_i};
    core_next.tog_sy = {core_reg.tog_sy[2:0], link_tog_reg};
    core_next.bit_sy = {core_reg.bit_sy[0], link_bit_reg};
    core_next.push   = 1'b0;
    if (start_ev)
    begin
      core_next.state = S_DEV;
      core_next.cnt   = SFI_CNT_RST;
      core_next.plan  = 1'b0;
      core_next.live  = 1'b0;
    end
    else if (stop_ev)
    begin
      core_next.state = S_IDLE;
      core_next.cnt   = SFI_CNT_RST;
      core_next.plan  = 1'b0;
      core_next.live  = 1'b0;
    end
    else if (rise_ev && is_busy(core_reg.state))
    begin
      core_next.live = 1'b1;
      if (core_reg.cnt != SFI_ACK_BIT)
      begin
        core_next.shreg = byte_in;
        core_next.cnt   = core_reg.cnt + 1'b1;
      end
      if (byte_done)
      begin
        case (core_reg.state)
          S_DEV:
          begin
            core_next.ack_ok = (byte_in[7:4] == DEV_TYPE);
            if (byte_in[7:4] == DEV_TYPE)
            begin
              core_next.rw         = byte_in[0];
              core_next.addr[10:8] = byte_in[3:1];
            end
          end
          S_WADDR:
          begin
            core_next.addr[7:0] = byte_in;
            core_next.ack_ok    = 1'b1;
          end
          S_WDATA:
          begin
            core_next.ack_ok = fifo_in_ready;
            core_next.wr     = '{addr: core_reg.addr, data: byte_in};
            core_next.push   = fifo_in_ready && !wp_on;
            core_next.addr   = core_reg.addr + SFI_ADDR_ONE;
          end
          S_RDATA:
          begin
            core_next.addr = core_reg.addr + SFI_ADDR_ONE;
          end
          default:
          begin
            core_next.ack_ok = 1'b0;
          end
        endcase
      end
      if (ack_slot)
      begin
        core_next.cnt = SFI_CNT_RST;
        case (core_reg.state)
          S_DEV:
          begin
            if (!core_reg.ack_ok)
            begin
              core_next.state = S_IDLE;
            end
            else if (core_reg.rw)
            begin
              core_next.state = S_RDATA;
              core_next.txd   = rd_q;
            end
            else
            begin
              core_next.state = S_WADDR;
            end
          end
          S_WADDR:
          begin
            core_next.state = S_WDATA;
          end
          S_WDATA:
          begin
            core_next.state = S_WDATA;
          end
          S_RDATA:
          begin
            if (bit_v)
            begin
              core_next.state = S_IDLE;
            end
            else
            begin
              core_next.txd = rd_q;
            end
          end
          default:
          begin
            core_next.state = S_IDLE;
          end
        endcase
      end
      // Whether to pull the line low at the coming fall
      core_next.plan = (core_next.cnt == SFI_ACK_BIT && core_next.ack_ok && is_rx(core_next.state)) ||
                       (core_next.state == S_RDATA && core_next.cnt != SFI_ACK_BIT &&
                        !core_next.txd[~core_next.cnt[2:0]]);
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      core_reg <= SFI_CORE_RST;
    end
    else
    begin
      core_reg <= core_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Write path and array; reads own the array port while sending
  assign drain_ready = (core_reg.state != S_RDATA);
  assign mem_we      = fifo_out_valid && drain_ready;

  sfi_fifo #(
    .W ($bits(sfi_wr_t)),
    .D (SFI_FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (mclk_i),
    .resetn_i    (resetn_i),
    .in_valid_i  (core_reg.push),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (core_reg.wr),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (drain_ready),
    .out_data_o  (fifo_out)
  );

  always_ff @(posedge mclk_i)
  begin
    if (mem_we)
    begin
      mem[fifo_out.addr] <= fifo_out.data;
    end
    rd_q <= mem[core_reg.addr];
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_byte_wr;
    byte_done && core_reg.state == S_WDATA;
  endsequence

  sequence s_commit;
    core_reg.push ##[1:16] mem_we;
  endsequence

  property p_commit;
    s_byte_wr and (!wp_on && fifo_in_ready) |=> s_commit;
  endproperty
  a_commit: assert property (p_commit) else $error("byte not committed");

  property p_wp;
    s_byte_wr and wp_on |=> !core_reg.push;
  endproperty
  a_wp: assert property (p_wp) else $error("write while protected");

  property p_ready;
    s_byte_wr and fifo_in_ready |=> core_reg.plan && core_reg.ack_ok;
  endproperty
  a_ready: assert property (p_ready) else $error("no acknowledge after write");

  property p_start;
    start_ev |=> core_reg.state == S_DEV && core_reg.cnt == SFI_CNT_RST;
  endproperty
  a_start: assert property (p_start) else $error("start did not restart");

  property p_stop;
    stop_ev |=> core_reg.state == S_IDLE ##1 sda_oe_n_o;
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not idle");

  property p_inc;
    byte_done && (core_reg.state == S_WDATA || core_reg.state == S_RDATA)
      |=> core_reg.addr == $past(core_reg.addr) + SFI_ADDR_ONE;
  endproperty
  a_inc: assert property (p_inc) else $error("address not advanced");

  property p_seg;
    byte_done && core_reg.state == S_DEV && byte_in[7:4] == DEV_TYPE
      |=> core_reg.addr[10:8] == $past(byte_in[3:1]) && core_reg.rw == $past(byte_in[0]);
  endproperty
  a_seg: assert property (p_seg) else $error("segment not latched");

  property p_nack;
    ack_slot && core_reg.state == S_RDATA && bit_v |=> core_reg.state == S_IDLE && !core_reg.plan;
  endproperty
  a_nack: assert property (p_nack) else $error("read did not end");

  property p_quiet;
    core_reg.state == S_IDLE && !core_reg.plan && !core_reg.scl_sy[1] |-> sda_oe_n_o;
  endproperty
  a_quiet: assert property (p_quiet) else $error("line driven while idle");

endmodule // sfi_target
`default_nettype wire
